// ### rtl/pgb_top.sv
/*
 pgb_top: per-generator termination qualifier select, leading-edge blanking,
 other-generator source select, phase/duty/adjust/period registers.
 assumes: plain register port (read data one cycle after read strobe),
 all inputs synchronous to clk_sys, synchronous active-high reset.
*/
`timescale 1ns/1ns
module pgb_top (
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic [2:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    input wire logic high_side_output,
    input wire logic low_side_output,
    input wire logic [7:0] gen_outputs,
    input wire logic [7:0] gen_present,
    input wire logic duty_active,
    input wire logic gen_triggered,
    input wire logic pci_src8,
    input wire logic pci_src9,
    input wire logic ctrl_input_active,
    output logic term_qualifier,
    output logic sw_term_input,
    output logic other_gen_out,
    output logic blanking_active,
    output logic [15:0] phase_out,
    output logic [15:0] period_out,
    output logic [15:0] eff_duty
);
    logic [15:0] pci_cfg_high;
    logic [15:0] blank_low;
    logic [15:0] blank_high;
    logic [15:0] phase_reg;
    logic [15:0] duty_reg;
    logic [15:0] duty_adj;
    logic [15:0] period_reg;
    logic [15:0] blank_cnt;
    logic [15:0] next_rdata;
    logic [15:0] blank_load;
    logic [15:0] status;
    logic [3:0] edge_trig;
    logic [3:0] edge_en;
    logic [3:0] edge_sig;
    logic any_edge;
    logic tq_raw;
    logic sw_bit_routed;
    logic ogen_sel;
    logic next_tq;
    logic [15:0] next_duty;

    // register writes; masks clear read-only and unimplemented bits
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            pci_cfg_high <= pgb_pkg::REG_RESET;
            blank_low <= pgb_pkg::REG_RESET;
            blank_high <= pgb_pkg::REG_RESET;
            phase_reg <= pgb_pkg::REG_RESET;
            duty_reg <= pgb_pkg::REG_RESET;
            duty_adj <= pgb_pkg::REG_RESET;
            period_reg <= pgb_pkg::REG_RESET;
        end else if (reg_wr) begin
            case (reg_addr)
                pgb_pkg::IDX_PCI_CFG_HIGH: begin
                    pci_cfg_high <= reg_wdata & pgb_pkg::MASK_PCI_CFG_HIGH;
                end
                pgb_pkg::IDX_BLANK_LOW: begin
                    blank_low <= reg_wdata & pgb_pkg::MASK_BLANK_LOW;
                end
                pgb_pkg::IDX_BLANK_HIGH: begin
                    blank_high <= reg_wdata & pgb_pkg::MASK_BLANK_HIGH;
                end
                pgb_pkg::IDX_PHASE: begin
                    phase_reg <= reg_wdata;
                end
                pgb_pkg::IDX_DUTY: begin
                    // no clamp: minimum duty is up to software
                    duty_reg <= reg_wdata;
                end
                pgb_pkg::IDX_DUTY_ADJ: begin
                    duty_adj <= reg_wdata & pgb_pkg::MASK_DUTY_ADJ;
                end
                pgb_pkg::IDX_PERIOD: begin
                    period_reg <= reg_wdata;
                end
                default: begin
                end
            endcase
        end
    end

    assign status = {12'h000, (ctrl_input_active), other_gen_out, term_qualifier, blanking_active};

    always_comb begin
        case (reg_addr)
            pgb_pkg::IDX_PCI_CFG_HIGH: next_rdata = pci_cfg_high;
            pgb_pkg::IDX_BLANK_LOW: next_rdata = blank_low;
            pgb_pkg::IDX_BLANK_HIGH: next_rdata = blank_high;
            pgb_pkg::IDX_PHASE: next_rdata = phase_reg;
            pgb_pkg::IDX_DUTY: next_rdata = duty_reg;
            pgb_pkg::IDX_DUTY_ADJ: next_rdata = duty_adj;
            pgb_pkg::IDX_PERIOD: next_rdata = period_reg;
            pgb_pkg::IDX_STATUS: next_rdata = status;
            default: next_rdata = pgb_pkg::REG_RESET;
        endcase
    end

    // read data stands for the one cycle after the strobe, zero otherwise
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            reg_rdata <= pgb_pkg::REG_RESET;
        end else if (reg_rd) begin
            reg_rdata <= next_rdata;
        end else begin
            reg_rdata <= pgb_pkg::REG_RESET;
        end
    end

    // edge enables: index 3..0 = high rise, high fall, low rise, low fall
    assign edge_en = {blank_high[pgb_pkg::HR_BIT], blank_high[pgb_pkg::HF_BIT],
                      blank_high[pgb_pkg::LR_BIT], blank_high[pgb_pkg::LF_BIT]};
    // one copy of each output per enable, in the same order as edge_en
    assign edge_sig = {high_side_output, high_side_output, low_side_output, low_side_output};

    pgb_edge_det u_edge_high (
        .clk_sys(clk_sys),
        .srst(srst),
        .sig(edge_sig[3]),
        .rise_en(edge_en[3]),
        .fall_en(edge_en[2]),
        .trig(edge_trig[1])
    );

    pgb_edge_det u_edge_low (
        .clk_sys(clk_sys),
        .srst(srst),
        .sig(edge_sig[1]),
        .rise_en(edge_en[1]),
        .fall_en(edge_en[0]),
        .trig(edge_trig[0])
    );

    assign edge_trig[3:2] = 2'b00;
    // only output edges start blanking; the other-generator source is not used
    assign any_edge = edge_trig[1] | edge_trig[0];

    // low bits dropped; zero field still yields the minimum of eight clocks
    assign blank_load = {blank_low[15:pgb_pkg::BLANK_SHIFT], 3'b000} + pgb_pkg::BLANK_MIN_CLKS;

    // retrigger on a fresh edge restarts the full interval
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            blank_cnt <= pgb_pkg::REG_RESET;
        end else if (any_edge) begin
            blank_cnt <= blank_load - 16'h0001;
        end else if (blank_cnt != 16'h0000) begin
            blank_cnt <= blank_cnt - 16'h0001;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            blanking_active <= 1'b0;
        end else if (any_edge) begin
            blanking_active <= 1'b1;
        end else if (blank_cnt == 16'h0000) begin
            blanking_active <= 1'b0;
        end
    end

    // absent generator reads as zero
    assign ogen_sel = gen_outputs[blank_high[pgb_pkg::OGEN_SEL_HI:pgb_pkg::OGEN_SEL_LO]]
                    & gen_present[blank_high[pgb_pkg::OGEN_SEL_HI:pgb_pkg::OGEN_SEL_LO]];

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            other_gen_out <= 1'b0;
        end else begin
            other_gen_out <= ogen_sel;
        end
    end

    assign sw_bit_routed = pci_cfg_high[pgb_pkg::SWCI_BIT]
        & (pci_cfg_high[pgb_pkg::SWCI_ROUTE_HI:pgb_pkg::SWCI_ROUTE_LO] == pgb_pkg::ROUTE_TERM_QUAL);

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            sw_term_input <= 1'b0;
        end else begin
            sw_term_input <= sw_bit_routed;
        end
    end

    always_comb begin
        case (pgb_pkg::pgb_tq_sel_t'(pci_cfg_high[pgb_pkg::TQ_SRC_HI:0]))
            pgb_pkg::PGB_TQ_FORCE1: tq_raw = 1'b1;
            pgb_pkg::PGB_TQ_DUTY: tq_raw = duty_active;
            pgb_pkg::PGB_TQ_BLANK: tq_raw = blanking_active;
            pgb_pkg::PGB_TQ_TRIG: tq_raw = gen_triggered;
            pgb_pkg::PGB_TQ_OGEN: tq_raw = ogen_sel;
            pgb_pkg::PGB_TQ_SRC8: tq_raw = pci_src8;
            pgb_pkg::PGB_TQ_SRC9: tq_raw = pci_src9;
            pgb_pkg::PGB_TQ_SW: tq_raw = 1'b0;
            default: tq_raw = 1'b0;
        endcase
    end
    assign next_tq = tq_raw ^ pci_cfg_high[pgb_pkg::TQ_POL_BIT];

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            term_qualifier <= 1'b0;
        end else begin
            term_qualifier <= next_tq;
        end
    end

    // 16-bit wrap on overflow is accepted; software keeps the sum in range
    assign next_duty = ctrl_input_active ? duty_reg + duty_adj : duty_reg;

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            eff_duty <= pgb_pkg::REG_RESET;
            phase_out <= pgb_pkg::REG_RESET;
            period_out <= pgb_pkg::REG_RESET;
        end else begin
            eff_duty <= next_duty;
            phase_out <= phase_reg;
            period_out <= period_reg;
        end
    end

    // assertions
    property p_blank_start;
        @(posedge clk_sys) disable iff (srst) any_edge |=> blanking_active;
    endproperty
    a_blank_start: assert property (p_blank_start) else $error("blanking not started");

    property p_blank_min;
        @(posedge clk_sys) disable iff (srst)
            (any_edge && blank_low[15:3] == 13'h0) ##1 !any_edge [*7] |-> blanking_active;
    endproperty
    a_blank_min: assert property (p_blank_min) else $error("blanking shorter than eight clocks");

    property p_blank_end;
        @(posedge clk_sys) disable iff (srst)
            (any_edge && blank_low[15:3] == 13'h0) ##1 !any_edge [*8] |=> !blanking_active;
    endproperty
    a_blank_end: assert property (p_blank_end) else $error("blanking longer than eight clocks");

    property p_hr_edge;
        @(posedge clk_sys) disable iff (srst)
            (edge_en[3] && $rose(high_side_output)) |=> blanking_active;
    endproperty
    a_hr_edge: assert property (p_hr_edge) else $error("high rise did not blank");

    property p_lf_edge;
        @(posedge clk_sys) disable iff (srst)
            (edge_en[0] && $fell(low_side_output)) |=> blanking_active;
    endproperty
    a_lf_edge: assert property (p_lf_edge) else $error("low fall did not blank");

    property p_no_edge_no_blank;
        @(posedge clk_sys) disable iff (srst)
            (!blanking_active && !any_edge) |=> !blanking_active;
    endproperty
    a_no_edge_no_blank: assert property (p_no_edge_no_blank) else $error("blanking without edge");

    property p_tq_force;
        @(posedge clk_sys) disable iff (srst)
            (pci_cfg_high[3:0] == 4'h0) |=> term_qualifier;
    endproperty
    a_tq_force: assert property (p_tq_force) else $error("forced qualifier not one");

    property p_tq_inv;
        @(posedge clk_sys) disable iff (srst)
            (pci_cfg_high[3:0] == 4'hF) |=> term_qualifier;
    endproperty
    a_tq_inv: assert property (p_tq_inv) else $error("inverted software qualifier not one");

    property p_duty_adj;
        @(posedge clk_sys) disable iff (srst)
            ctrl_input_active |=> eff_duty == $past(duty_reg) + $past(duty_adj);
    endproperty
    a_duty_adj: assert property (p_duty_adj) else $error("effective duty wrong");

    property p_low_bits;
        @(posedge clk_sys) disable iff (srst) blank_low[2:0] == 3'b000 && duty_adj[15:8] == 8'h00;
    endproperty
    a_low_bits: assert property (p_low_bits) else $error("read-only bits set");
endmodule // pgb_top

// ### rtl/pgb_pkg.sv
/*
 pgb_pkg: register indices, field positions, reset values and codes for the
 pwm generator blanking / duty / period block.
 assumes: 16-bit register port, one clock (clk_sys, 10 MHz), synchronous reset.
*/
package pgb_pkg;
    localparam int DW = 16;
    localparam int AW = 3;
    // register indices on the plain register port
    localparam logic [2:0] IDX_PCI_CFG_HIGH = 3'h0;
    localparam logic [2:0] IDX_BLANK_LOW = 3'h1;
    localparam logic [2:0] IDX_BLANK_HIGH = 3'h2;
    localparam logic [2:0] IDX_PHASE = 3'h3;
    localparam logic [2:0] IDX_DUTY = 3'h4;
    localparam logic [2:0] IDX_DUTY_ADJ = 3'h5;
    localparam logic [2:0] IDX_PERIOD = 3'h6;
    localparam logic [2:0] IDX_STATUS = 3'h7;
    localparam logic [15:0] REG_RESET = 16'h0000;
    // write masks: unimplemented and read-only bits hold zero
    localparam logic [15:0] MASK_PCI_CFG_HIGH = 16'hF7FF;
    localparam logic [15:0] MASK_BLANK_LOW = 16'hFFF8;
    localparam logic [15:0] MASK_BLANK_HIGH = 16'h070F;
    localparam logic [15:0] MASK_DUTY_ADJ = 16'h00FF;
    // control-input config high fields
    localparam int SWCI_BIT = 7;
    localparam int SWCI_ROUTE_HI = 6;
    localparam int SWCI_ROUTE_LO = 5;
    localparam int TQ_POL_BIT = 3;
    localparam int TQ_SRC_HI = 2;
    localparam logic [1:0] ROUTE_TERM_QUAL = 2'h2;
    // blanking high fields
    localparam int OGEN_SEL_HI = 10;
    localparam int OGEN_SEL_LO = 8;
    localparam int HR_BIT = 3;
    localparam int HF_BIT = 2;
    localparam int LR_BIT = 1;
    localparam int LF_BIT = 0;
    // blanking low: bits below this are ignored
    localparam int BLANK_SHIFT = 3;
    localparam int BLANK_CNT_W = 16;
    localparam logic [15:0] BLANK_MIN_CLKS = 16'h0008;
    localparam int NUM_GEN = 8;
    localparam int DUTY_ADJ_W = 8;
    // status register bits
    localparam int ST_BLANK_BIT = 0;
    localparam int ST_TQ_BIT = 1;
    localparam int ST_OGEN_BIT = 2;
    localparam int ST_ADJ_BIT = 3;
    typedef enum logic [2:0] {
        PGB_TQ_FORCE1,
        PGB_TQ_DUTY,
        PGB_TQ_BLANK,
        PGB_TQ_TRIG,
        PGB_TQ_OGEN,
        PGB_TQ_SRC8,
        PGB_TQ_SRC9,
        PGB_TQ_SW
    } pgb_tq_sel_t;
endpackage

// ### rtl/pgb_edge_det.sv
/*
 pgb_edge_det: rising / falling edge detector for one output; trigger is combinational, only the previous level is registered.
 assumes: input synchronous to clk_sys.
*/
`timescale 1ns/1ns
module pgb_edge_det (
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic sig,
    input wire logic rise_en,
    input wire logic fall_en,
    output logic trig
);
    logic prev;
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            prev <= 1'b0;
        end else begin
            prev <= sig;
        end
    end
    // an edge counts only when its enable is set
    assign trig = (rise_en & sig & ~prev) | (fall_en & ~sig & prev);
endmodule // pgb_edge_det

// ### testbench/tb.sv
/*
 tb: self-checking bench for pgb_top, driving every port directly.
 assumes: pgb_pkg compiled first; clk_sys 10 MHz, synchronous active-high srst.
*/
`timescale 1ns/1ns
module tb;
    logic clk_sys = 1'b0;
    logic srst = 1'b1;
    logic [2:0] reg_addr = 3'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [15:0] reg_rdata;
    logic hs = 1'b0;
    logic ls = 1'b0;
    logic [7:0] gen_outputs = 8'h00;
    logic [7:0] gen_present = 8'hff;
    logic duty_active = 1'b0;
    logic gen_triggered = 1'b0;
    logic pci_src8 = 1'b0;
    logic pci_src9 = 1'b0;
    logic ctrl = 1'b0;
    logic term_qualifier, sw_term_input, other_gen_out, blanking_active;
    logic [15:0] phase_out, period_out, eff_duty;
    int miscompares = 0;
    int compares = 0;
    logic [15:0] d;
    logic [15:0] msk [7];
    int n;

    always #50 clk_sys = ~clk_sys;

    pgb_top i_pgb_top (.clk_sys(clk_sys), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .high_side_output(hs),
        .low_side_output(ls), .gen_outputs(gen_outputs), .gen_present(gen_present),
        .duty_active(duty_active), .gen_triggered(gen_triggered), .pci_src8(pci_src8),
        .pci_src9(pci_src9), .ctrl_input_active(ctrl), .term_qualifier(term_qualifier),
        .sw_term_input(sw_term_input), .other_gen_out(other_gen_out), .blanking_active(blanking_active),
        .phase_out(phase_out), .period_out(period_out), .eff_duty(eff_duty));

    task automatic report_and_stop;
        if (miscompares == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic tick(input int k);
        repeat (k) @(posedge clk_sys);
        #1;
    endtask

    task automatic wr(input logic [2:0] a, input logic [15:0] v);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [2:0] a, output logic [15:0] v);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask

    // bit7 sw bit, 6:5 route, 3 polarity, 2:0 qualifier source
    task automatic cfg(input logic pol, input logic [2:0] c, input logic [1:0] rt, input logic sw);
        wr(pgb_pkg::IDX_PCI_CFG_HIGH, {8'h00, sw, rt, 1'b0, pol, c});
    endtask

    // selected source gets s, every other source the opposite, so a wrong pick shows
    task automatic drv(input int c, input logic s);
        @(posedge clk_sys);
        duty_active <= (c == 1) ? s : !s;
        gen_triggered <= (c == 3) ? s : !s;
        gen_outputs <= {7'h00, (c == 4) ? s : !s};
        pci_src8 <= (c == 5) ? s : !s;
        pci_src9 <= (c == 6) ? s : !s;
    endtask

    task automatic side(input logic hi, input logic v);
        @(posedge clk_sys);
        if (hi) begin
            hs <= v;
        end else begin
            ls <= v;
        end
    endtask

    // length of the next blanking pulse; a pulse that never ends counts as a hang
    task automatic meas(output int len);
        int w;
        len = 0;
        for (w = 0; w < 3 && blanking_active !== 1'b1; w++) tick(1);
        while (blanking_active === 1'b1 && len < 300) begin
            len++;
            tick(1);
        end
        if (len >= 300) begin
            miscompares++;
            report_and_stop();
        end
    endtask

    initial begin
        msk = '{pgb_pkg::MASK_PCI_CFG_HIGH, pgb_pkg::MASK_BLANK_LOW, pgb_pkg::MASK_BLANK_HIGH, 16'hffff,
            16'hffff, pgb_pkg::MASK_DUTY_ADJ, 16'hffff};
        repeat (12) @(posedge clk_sys);
        srst <= 1'b0;
        for (int i = 0; i < 7; i++) begin
            rd(3'(i), d);
            chk("reset_value", d, pgb_pkg::REG_RESET);
        end
        for (int i = 0; i < 7; i++) begin
            wr(3'(i), 16'hffff);
            rd(3'(i), d);
            chk("write_mask", d, msk[i]);
            wr(3'(i), 16'h0000);
        end
        // termination qualifier: every code, both polarities, both source levels
        for (int p = 0; p < 2; p++) begin
            for (int c = 0; c < 8; c++) begin
                cfg(p[0], 3'(c), 2'h0, 1'b0);
                for (int s = 0; s < 2; s++) begin
                    drv(c, s[0]);
                    tick(3);
                    chk("term_qualifier", {15'h0000, term_qualifier},
                        {15'h0000, ((c == 0) ? 1'b1 : (c == 7 || c == 2) ? 1'b0 : s[0]) ^ p[0]});
                end
            end
        end
        // other generator pick, present and absent, seen directly and through qualifier code 100
        cfg(1'b0, 3'h4, 2'h0, 1'b0);
        for (int g = 0; g < 8; g++) begin
            wr(pgb_pkg::IDX_BLANK_HIGH, {5'h00, 3'(g), 8'h00});
            @(posedge clk_sys);
            gen_outputs <= 8'h01 << g;
            tick(3);
            chk("other_gen_out", {15'h0000, other_gen_out}, 16'h0001);
            chk("term_qualifier", {15'h0000, term_qualifier}, 16'h0001);
            @(posedge clk_sys);
            gen_outputs <= ~(8'h01 << g);
            tick(3);
            chk("other_gen_out", {15'h0000, other_gen_out}, 16'h0000);
            @(posedge clk_sys);
            gen_outputs <= 8'hff;
            gen_present <= ~(8'h01 << g);
            tick(3);
            chk("other_gen_out", {15'h0000, other_gen_out}, 16'h0000);
            chk("term_qualifier", {15'h0000, term_qualifier}, 16'h0000);
            @(posedge clk_sys);
            gen_present <= 8'hff;
        end
        // software bit reaches the termination path only for route 10
        for (int r = 0; r < 4; r++) begin
            cfg(1'b0, 3'h7, 2'(r), 1'b1);
            tick(3);
            chk("sw_term_input", {15'h0000, sw_term_input}, {15'h0000, r == 2});
            chk("term_qualifier", {15'h0000, term_qualifier}, 16'h0000);
        end
        // each enable alone: the opposite edge is ignored, its own edge blanks eight clocks
        wr(pgb_pkg::IDX_BLANK_HIGH, 16'h0000);
        for (int b = 3; b >= 0; b--) begin
            wr(pgb_pkg::IDX_BLANK_HIGH, 16'h0000);
            side(b >= 2, b % 2 == 1);
            wr(pgb_pkg::IDX_BLANK_HIGH, 16'h0001 << b);
            side(b >= 2, b % 2 == 0);
            meas(n);
            chk("blank_len_off", 16'(n), 16'h0000);
            side(b >= 2, b % 2 == 1);
            meas(n);
            chk("blank_len", 16'(n), 16'h0008);
        end
        // duration follows the upper thirteen bits, low three ignored, floor of eight
        wr(pgb_pkg::IDX_BLANK_HIGH, 16'h000c);
        foreach (msk[i]) begin
            d = (i % 4 == 0) ? 16'h0000 : (i % 4 == 1) ? 16'h0007 : (i % 4 == 2) ? 16'h0008 : 16'h0017;
            wr(pgb_pkg::IDX_BLANK_LOW, d);
            side(1'b1, !hs);
            meas(n);
            chk("blank_len", 16'(n), {d[15:3], 3'h0} + 16'h0008);
        end
        wr(pgb_pkg::IDX_BLANK_HIGH, 16'h000f);
        @(posedge clk_sys);
        gen_outputs <= 8'h00;
        meas(n);
        chk("blank_from_other_gen", 16'(n), 16'h0000);
        cfg(1'b0, 3'h2, 2'h0, 1'b0);
        side(1'b0, !ls);
        tick(4);
        chk("term_qualifier_blank", {15'h0000, term_qualifier}, 16'h0001);
        meas(n);
        // duty adjustment, including the 16-bit wrap, and plain register copies
        wr(pgb_pkg::IDX_DUTY, 16'h0100);
        wr(pgb_pkg::IDX_DUTY_ADJ, 16'h12ff);
        tick(3);
        chk("eff_duty", eff_duty, 16'h0100);
        @(posedge clk_sys);
        ctrl <= 1'b1;
        tick(3);
        chk("eff_duty", eff_duty, 16'h01ff);
        wr(pgb_pkg::IDX_DUTY, 16'hfff8);
        wr(pgb_pkg::IDX_DUTY_ADJ, 16'h0010);
        tick(3);
        chk("eff_duty", eff_duty, 16'h0008);
        wr(pgb_pkg::IDX_PHASE, 16'h1234);
        wr(pgb_pkg::IDX_PERIOD, 16'h0010);
        tick(3);
        chk("phase_out", phase_out, 16'h1234);
        chk("period_out", period_out, 16'h0010);
        // status ignores writes and mirrors the control-input level
        wr(pgb_pkg::IDX_STATUS, 16'h0000);
        rd(pgb_pkg::IDX_STATUS, d);
        chk("status_ctrl", d & 16'h0008, 16'h0008);
        report_and_stop();
    end
endmodule // tb
